// ===== common/lfrc_cfg.svh
// register offsets, reset values and field positions of the lf receiver bank
`ifndef LFRC_CFG_SVH
`define LFRC_CFG_SVH

// ----------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------
`define LFRC_FRONT_END_IDX        8'h2a
`define LFRC_SLICER_FILTER_IDX    8'h2b
`define LFRC_STATUS_IDX           8'h29
`define LFRC_FRONT_END_ADDR       10'h0a8
`define LFRC_SLICER_FILTER_ADDR   10'h0ac
`define LFRC_STATUS_ADDR          10'h0a4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LFRC_FRONT_END_RST        8'hc8
`define LFRC_SLICER_FILTER_RST    8'hc4
`define LFRC_STATUS_RST           8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LFRC_GAIN_MSB             7
`define LFRC_GAIN_LSB             6
`define LFRC_FINAL_MSB            5
`define LFRC_FINAL_LSB            4
`define LFRC_AZ_EN_BIT            3
`define LFRC_DAMP_MSB             2
`define LFRC_DAMP_LSB             1
`define LFRC_DAMP_EN_BIT          0
`define LFRC_HYST_MSB             7
`define LFRC_HYST_LSB             6
`define LFRC_BIPHASE_BIT          5
`define LFRC_OFFSET_BIT           4
`define LFRC_POL_BIT              3
`define LFRC_AZCNT_MSB            2
`define LFRC_AZCNT_LSB            0
`define LFRC_DAMP_ACT_BIT         5

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define LFRC_RESP_OKAY            2'h0
`define LFRC_RESP_SLVERR          2'h2

`endif

// ===== common/lfrc_pkg.sv
// types shared by the lf receiver control bank
package lfrc_pkg;

  typedef enum logic [1:0] {
    LFRC_FILT_LOWPASS  = 2'h0,
    LFRC_FILT_LOWPASS2 = 2'h1,
    LFRC_FILT_BP_LOW   = 2'h2,
    LFRC_FILT_BP_HIGH  = 2'h3
  } lfrc_filter_type;

  typedef enum logic [2:0] {
    LFRC_ST_IDLE = 3'b001,
    LFRC_ST_RUN  = 3'b010,
    LFRC_ST_HOLD = 3'b100
  } lfrc_az_state_type;

endpackage

// ===== dv/lf_receiver_control_regs_tb.sv
// self-checking bench for the lf receiver control bank
`timescale 1ns/100ps
`default_nettype none

`include "lfrc_cfg.svh"

module lf_receiver_control_regs_tb;
  import lfrc_pkg::*;
  // ----------------------------------------------------------------
  // signals and model
  // ----------------------------------------------------------------
  localparam logic [9:0] a_fe = `LFRC_FRONT_END_ADDR;
  localparam logic [9:0] a_sl = `LFRC_SLICER_FILTER_ADDR;
  localparam logic [9:0] a_st = `LFRC_STATUS_ADDR;
  logic aclk, aresetn, rx_soft_reset, in_frame, data_edge, carrier_mode;
  logic damping_allowed, mid_rise, mid_fall, fourth_rectifier_off;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, input_damping_enable;
  logic biphase_filter_select, biphase_offset_select, autozero_request;
  logic decoded_bit_valid, decoded_bit;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, third_stage_gain_sel;
  logic [1:0]  final_stage_sel, damping_resistor_sel;
  logic [1:0]  slicer_threshold_margin_sel;
  logic [7:0]  v, w;
  lfrc_filter_type filter_mode;
  int n_mismatch, n_checks, fe, sl;

  lfrc_control_regs u_lfrc_control_regs (
    .aclk, .aresetn, .rx_soft_reset, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .in_frame, .data_edge, .carrier_mode, .damping_allowed,
    .mid_rise, .mid_fall, .third_stage_gain_sel, .final_stage_sel,
    .fourth_rectifier_off, .damping_resistor_sel, .input_damping_enable,
    .slicer_threshold_margin_sel, .biphase_filter_select,
    .biphase_offset_select, .filter_mode, .autozero_request,
    .decoded_bit_valid, .decoded_bit
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // bready and rready stay high, so every answer is taken where seen
  task automatic wr(input logic [9:0] a, input logic [7:0] d,
                    input logic [3:0] sb, input logic [1:0] er);
    int t;
    t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= sb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && t < 50);
    chk(s_axi_bvalid, 1'h1);
    chk(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    int t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && t < 50);
    chk(s_axi_rvalid, 1'h1);
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask

  task automatic fields;
    chk(third_stage_gain_sel, fe[7:6]);
    chk(final_stage_sel, fe[5:4]);
    chk(fourth_rectifier_off, fe[5]);
    chk(damping_resistor_sel, fe[2:1]);
    chk(input_damping_enable, fe[0]);
    chk(slicer_threshold_margin_sel, sl[7:6]);
    chk(biphase_filter_select, sl[5]);
    chk(biphase_offset_select, sl[4]);
    chk(filter_mode, sl[5:4]);
  endtask

  task automatic rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    fe = 200;
    sl = 196;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    {aresetn, rx_soft_reset, in_frame, data_edge, carrier_mode} = 5'h0;
    {damping_allowed, mid_rise, mid_fall} = 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 56'h0;
    n_mismatch = 0;
    n_checks = 0;
    v = 8'($urandom(32'h0141));
    rst();
    rd(a_fe, fe, 2'h0);
    rd(a_sl, sl, 2'h0);
    fields();
    // first four passes set every code of every field except the three-bit edge count, which gets 0, 2, 5 and 7
    for (int i = 0; i < 24; i++) begin
      v = (i < 4) ? {i[1:0], i[1:0], i[0], i[1:0], i[1]} : 8'($urandom);
      w = (i < 4) ? v : 8'($urandom);
      wr(a_fe, v, 4'h1, 2'h0);
      wr(a_sl, w, 4'h1, 2'h0);
      fe = v;
      sl = w;
      fields();
      rd(a_fe, fe, 2'h0);
      rd(a_sl, sl, 2'h0);
    end
    wr(a_fe, 8'h00, 4'h0, 2'h0);
    rd(a_fe, fe, 2'h0);
    damping_allowed <= 1'b1;
    wr(a_fe, 8'h01, 4'h1, 2'h0);
    fe = 1;
    rd(a_st, 32'h20, 2'h0);
    wr(a_st, 8'h00, 4'h1, 2'h0);
    rd(a_st, 32'h20, 2'h0);
    // enabled but not allowed must not read as active
    damping_allowed <= 1'b0;
    @(posedge aclk);
    rd(a_st, 32'h0, 2'h0);
    wr(10'h100, 8'hff, 4'h1, 2'h2);
    rd(10'h02a, 32'h0, 2'h2);
    rd(a_fe, fe, 2'h0);
    @(posedge aclk);
    rx_soft_reset <= 1'b1;
    @(posedge aclk);
    rx_soft_reset <= 1'b0;
    // reload lands on the edge above, so look one edge later
    @(posedge aclk);
    fe = 200;
    sl = 196;
    fields();
    rd(a_sl, sl, 2'h0);
    for (int i = 0; i < 4; i++) begin
      wr(a_sl, i[1] ? 8'h08 : 8'h00, 4'h1, 2'h0);
      @(posedge aclk);
      mid_rise <= i[0];
      mid_fall <= !i[0];
      @(posedge aclk);
      {mid_rise, mid_fall} <= 2'h0;
      // sample on an edge so the next write also starts on one
      @(posedge aclk);
      chk(decoded_bit_valid, 1'h1);
      chk(decoded_bit, i[0] ^ i[1]);
    end
    @(posedge aclk);
    {carrier_mode, mid_rise} <= 2'h3;
    @(posedge aclk);
    mid_rise <= 1'b0;
    #1 chk(decoded_bit_valid, 1'h0);
    @(posedge aclk);
    carrier_mode <= 1'b0;
    // advised setup, carrier preamble first, then manchester preamble
    fe = 24;
    sl = 6;
    wr(a_fe, 8'(fe), 4'h1, 2'h0);
    wr(a_sl, 8'(sl), 4'h1, 2'h0);
    fields();
    sl = 198;
    wr(a_sl, 8'(sl), 4'h1, 2'h0);
    fields();
    // edge counts 3 and the advised 6, auto-zero off then on
    for (int c = 3; c <= 6; c += 3) begin
      wr(a_sl, 8'(c), 4'h1, 2'h0);
      for (int en = 0; en < 2; en++) begin
        wr(a_fe, en ? 8'h08 : 8'h00, 4'h1, 2'h0);
        in_frame <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int k = 1; k <= c; k++) begin
          @(posedge aclk);
          data_edge <= 1'b1;
          @(posedge aclk);
          data_edge <= 1'b0;
          #1 chk(autozero_request, en == 1 && k == c);
        end
        @(posedge aclk);
        in_frame <= 1'b0;
        repeat (3) @(posedge aclk);
      end
    end
    rst();
    rd(a_fe, fe, 2'h0);
    rd(a_sl, sl, 2'h0);
    tally_and_finish();
  end
endmodule

`default_nettype wire

// ===== dv/lfrc_control_regs_asserts.sv
// port assertions for the lf receiver control bank
`timescale 1ns/100ps
`default_nettype none

module lfrc_control_regs_asserts
  import lfrc_pkg::*;
(
  // clock and resets
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             rx_soft_reset,
  // bus handshakes
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic [31:0]      s_axi_rdata,
  // receiver side
  input wire logic             carrier_mode,
  input wire logic             mid_rise,
  input wire logic             mid_fall,
  input wire logic [1:0]       third_stage_gain_sel,
  input wire logic [1:0]       final_stage_sel,
  input wire logic             fourth_rectifier_off,
  input wire logic [1:0]       slicer_threshold_margin_sel,
  input wire logic             biphase_filter_select,
  input wire logic             biphase_offset_select,
  input wire lfrc_filter_type  filter_mode,
  input wire logic             decoded_bit_valid
);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence mid_edge;
    (mid_rise ^ mid_fall) && !carrier_mode;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  front_reload_a: assert property (rx_soft_reset |=>
    third_stage_gain_sel == 2'h3 && final_stage_sel == 2'h0)
    else $error("front-end not reloaded");
  slicer_reload_a: assert property (rx_soft_reset |=>
    slicer_threshold_margin_sel == 2'h3 && !biphase_filter_select)
    else $error("slicer not reloaded");
  rect_off_a: assert property (
    fourth_rectifier_off == final_stage_sel[1])
    else $error("rectifier off wrong");
  filter_map_a: assert property (
    filter_mode == {biphase_filter_select, biphase_offset_select})
    else $error("filter mode wrong");
  write_resp_a: assert property (wr_taken |=> s_axi_bvalid)
    else $error("no write response");
  one_write_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  read_data_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer wrong");
  decode_a: assert property (mid_edge |=> decoded_bit_valid)
    else $error("mid-bit edge not decoded");
  carrier_a: assert property ((mid_rise || mid_fall)
    && carrier_mode |=> !decoded_bit_valid)
    else $error("decoded in carrier mode");
endmodule

bind lfrc_control_regs lfrc_control_regs_asserts u_lfrc_control_regs_asserts (
  .aclk, .aresetn, .rx_soft_reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .carrier_mode, .mid_rise,
  .mid_fall, .third_stage_gain_sel, .final_stage_sel, .fourth_rectifier_off,
  .slicer_threshold_margin_sel, .biphase_filter_select,
  .biphase_offset_select, .filter_mode, .decoded_bit_valid
);

`default_nettype wire

// ===== logic/lfrc_autozero_trigger.sv
// auto-zero request after a programmed number of data edges
`timescale 1ns/100ps
`default_nettype none

module lfrc_autozero_trigger
  import lfrc_pkg::*;
#(
  parameter int CNT_W = 3
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // frame and edge events
  input  wire logic             in_frame,
  input  wire logic             data_edge,
  // settings
  input  wire logic             az_enable,
  input  wire logic [CNT_W-1:0] edge_count,
  // request
  output logic                  az_request
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lfrc_az_state_type state_reg;
  lfrc_az_state_type state_next;
  logic [CNT_W-1:0]  count_reg;
  logic [CNT_W-1:0]  count_next;
  logic              req_next;

  // count of zero still needs one edge, never a free-running request
  wire reached = data_edge && ((count_reg + 1'b1) >= edge_count);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    req_next   = 1'b0;
    unique case (state_reg)
      LFRC_ST_IDLE: begin
        count_next = '0;
        if (in_frame && az_enable) begin
          state_next = LFRC_ST_RUN;
        end
      end
      LFRC_ST_RUN: begin
        if (!in_frame || !az_enable) begin
          state_next = LFRC_ST_IDLE;
        end else if (reached) begin
          req_next   = 1'b1;
          count_next = '0;
          state_next = LFRC_ST_HOLD;
        end else if (data_edge) begin
          count_next = count_reg + 1'b1;
        end
      end
      LFRC_ST_HOLD: begin
        state_next = in_frame ? LFRC_ST_RUN : LFRC_ST_IDLE;
      end
      default: begin
        state_next = LFRC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg  <= LFRC_ST_IDLE;
      count_reg  <= '0;
      az_request <= 1'b0;
    end else begin
      state_reg  <= state_next;
      count_reg  <= count_next;
      az_request <= req_next;
    end
  end

endmodule

`default_nettype wire

// ===== logic/lfrc_control_regs.sv
// lf receiver front-end and slicer/filter control registers on axi4-lite
`timescale 1ns/100ps
`default_nettype none

`include "lfrc_cfg.svh"

module lfrc_control_regs
  import lfrc_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  // clock and resets
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              rx_soft_reset,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // receiver events
  input  wire logic              in_frame,
  input  wire logic              data_edge,
  input  wire logic              carrier_mode,
  input  wire logic              damping_allowed,
  input  wire logic              mid_rise,
  input  wire logic              mid_fall,
  // analogue settings
  output logic [1:0]             third_stage_gain_sel,
  output logic [1:0]             final_stage_sel,
  output logic                   fourth_rectifier_off,
  output logic [1:0]             damping_resistor_sel,
  output logic                   input_damping_enable,
  output logic [1:0]             slicer_threshold_margin_sel,
  output logic                   biphase_filter_select,
  output logic                   biphase_offset_select,
  output lfrc_filter_type        filter_mode,
  // receiver results
  output logic                   autozero_request,
  output logic                   decoded_bit_valid,
  output logic                   decoded_bit
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]        front_end_reg;
  logic [7:0]        slicer_reg;
  logic              damp_active_reg;
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0]        wdata_reg;
  logic              wstrb0_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(`LFRC_FRONT_END_ADDR)) begin
      reg_sel = 2'h1;
    end else if (a == ADDR_W'(`LFRC_SLICER_FILTER_ADDR)) begin
      reg_sel = 2'h2;
    end else if (a == ADDR_W'(`LFRC_STATUS_ADDR)) begin
      reg_sel = 2'h3;
    end else begin
      reg_sel = 2'h0;
    end
  endfunction

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  // one write at a time: address and data are held until the response
  wire aw_take = s_axi_awvalid && !aw_held_reg && !bvalid_reg;
  wire w_take  = s_axi_wvalid && !w_held_reg && !bvalid_reg;
  wire aw_have = aw_held_reg || aw_take;
  wire w_have  = w_held_reg || w_take;
  wire wr_fire = aw_have && w_have && !bvalid_reg;

  wire [ADDR_W-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [7:0]        wr_byte = w_held_reg ? wdata_reg : s_axi_wdata[7:0];
  wire              wr_lane = w_held_reg ? wstrb0_reg : s_axi_wstrb[0];
  wire [1:0]        wr_sel  = reg_sel(wr_addr);

  // status register is read-only; writes to it are accepted and dropped
  wire wr_front  = wr_fire && wr_lane && (wr_sel == 2'h1);
  wire wr_slicer = wr_fire && wr_lane && (wr_sel == 2'h2);
  wire wr_bad    = wr_sel == 2'h0;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 8'h00;
      wstrb0_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `LFRC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg  <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      aw_held_reg <= aw_have && !wr_fire;
      w_held_reg  <= w_have && !wr_fire;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_bad ? `LFRC_RESP_SLVERR : `LFRC_RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // bus reset stands in for power-on; the receiver soft reset reloads
  // too, and no other reset reaches these flops
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_soft_reset) begin
      front_end_reg <= `LFRC_FRONT_END_RST;
      slicer_reg    <= `LFRC_SLICER_FILTER_RST;
    end else begin
      if (wr_front) begin
        front_end_reg <= wr_byte;
      end
      if (wr_slicer) begin
        slicer_reg <= wr_byte;
      end
    end
  end

  // damping is only truly active when enabled and the receiver allows it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      damp_active_reg <= 1'b0;
    end else begin
      damp_active_reg <= input_damping_enable && damping_allowed;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  wire [1:0] rd_sel  = reg_sel(s_axi_araddr);
  wire       rd_take = s_axi_arvalid && !rvalid_reg;

  logic [7:0] rd_byte;
  always_comb begin
    unique case (rd_sel)
      2'h1: rd_byte = front_end_reg;
      2'h2: rd_byte = slicer_reg;
      2'h3: begin
        rd_byte = `LFRC_STATUS_RST;
        rd_byte[`LFRC_DAMP_ACT_BIT] = damp_active_reg;
      end
      2'h0: rd_byte = 8'h00;
    endcase
  end

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `LFRC_RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= (rd_sel == 2'h0) ? `LFRC_RESP_SLVERR : `LFRC_RESP_OKAY;
      rdata_reg  <= {24'h00_0000, rd_byte};
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  assign third_stage_gain_sel =
    front_end_reg[`LFRC_GAIN_MSB:`LFRC_GAIN_LSB];
  assign final_stage_sel =
    front_end_reg[`LFRC_FINAL_MSB:`LFRC_FINAL_LSB];
  assign fourth_rectifier_off = front_end_reg[`LFRC_FINAL_MSB];
  assign damping_resistor_sel =
    front_end_reg[`LFRC_DAMP_MSB:`LFRC_DAMP_LSB];
  assign input_damping_enable = front_end_reg[`LFRC_DAMP_EN_BIT];
  assign slicer_threshold_margin_sel =
    slicer_reg[`LFRC_HYST_MSB:`LFRC_HYST_LSB];
  assign biphase_filter_select = slicer_reg[`LFRC_BIPHASE_BIT];
  assign biphase_offset_select = slicer_reg[`LFRC_OFFSET_BIT];
  assign filter_mode =
    lfrc_filter_type'(slicer_reg[`LFRC_BIPHASE_BIT:`LFRC_OFFSET_BIT]);

  // ----------------------------------------------------------------
  // receiver helpers
  // ----------------------------------------------------------------
  lfrc_autozero_trigger #(
    .CNT_W (3)
  ) u_az (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .in_frame   (in_frame),
    .data_edge  (data_edge),
    .az_enable  (front_end_reg[`LFRC_AZ_EN_BIT]),
    .edge_count (slicer_reg[`LFRC_AZCNT_MSB:`LFRC_AZCNT_LSB]),
    .az_request (autozero_request)
  );

  lfrc_manchester_decode u_dec (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .mid_rise     (mid_rise),
    .mid_fall     (mid_fall),
    .carrier_mode (carrier_mode),
    .polarity     (slicer_reg[`LFRC_POL_BIT]),
    .bit_valid    (decoded_bit_valid),
    .bit_value    (decoded_bit)
  );

endmodule

`default_nettype wire

// ===== logic/lfrc_manchester_decode.sv
// mid-bit manchester edge to data bit translation
`timescale 1ns/100ps
`default_nettype none

module lfrc_manchester_decode (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // demodulated edge events
  input  wire logic mid_rise,
  input  wire logic mid_fall,
  input  wire logic carrier_mode,
  // settings
  input  wire logic polarity,
  // decoded bits
  output logic      bit_valid,
  output logic      bit_value
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire edge_seen = (mid_rise ^ mid_fall) & ~carrier_mode;
  // falling means zero unless polarity swaps the meaning
  wire bit_dec   = mid_rise ^ polarity;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_valid <= 1'b0;
      bit_value <= 1'b0;
    end else begin
      bit_valid <= edge_seen;
      if (edge_seen) begin
        bit_value <= bit_dec;
      end
    end
  end

endmodule

`default_nettype wire
